// ### src/facs_top.sv
// Flash array control sequencer with AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
module facs_top #(
  parameter logic [23:0] ERASE_MIN_CYC = 24'(facs_pkg::ERASE_CYC),
  parameter logic [23:0] MASS_MIN_CYC  = 24'(facs_pkg::MASS_CYC),
  parameter logic [23:0] NVH1_RST_CYC  = 24'(facs_pkg::NVH1_CYC),
  parameter logic [23:0] HV_BUDGET_CYC = 24'(facs_pkg::HV_CYC)
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output facs_pkg::facs_ctrl_t       flash_ctrl,
  input  wire logic [15:0]           flash_rdata,
  output logic                       busy
);

  typedef struct packed {
    facs_pkg::facs_seq_t  st;
    logic [23:0]          cnt;
    facs_pkg::facs_op_t   cfg_op;
    logic                 cfg_info;
    logic                 cfg_manual;
    facs_pkg::facs_op_t   act_op;
    logic                 act_info;
    logic                 act_manual;
    logic [7:0]           addr;
    logic [15:0]          wdata;
    logic [15:0]          rdata;
    logic [7:0][23:0]     tm;
    logic                 busy;
    logic                 done;
    logic                 ref_busy;
    logic                 ref_reprog;
    logic                 ref_budget;
    facs_pkg::facs_ctrl_t ctrl;
    logic [511:0]         prog_map;
    logic [31:0][23:0]    hv_acc;
    logic                 aw_have;
    logic                 w_have;
    logic [7:0]           awaddr;
    logic [31:0]          wdat;
    logic [3:0]           wstrb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdat;
    logic [1:0]           rresp;
  } facs_state_t;

  facs_state_t s_q;
  facs_state_t s_d;
  facs_state_t s_rst;
  logic        start;
  logic [4:0]  clr;
  logic [31:0] wv;
  logic [8:0]  widx;
  logic [4:0]  ridx;
  logic [23:0] plen;
  logic [24:0] hv_sum;
  logic [2:0]  tidx;
  logic [3:0]  tsel;
  logic [33:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Timing register index of a word address, bit 3 flags out of range
  function automatic logic [3:0] time_index(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w >= facs_pkg::REG_TIME0 && w <= facs_pkg::REG_TIME7)
    begin
      return {1'b0, 3'((w - facs_pkg::REG_TIME0) >> 2)};
    end
    return 4'h8;
  endfunction

  // Setup, hold and recovery: nonzero register value in manual mode, one cycle otherwise
  function automatic logic [23:0] step_len(input logic manual, input logic [23:0] v);
    if (manual && v != 24'h000000)
    begin
      return v;
    end
    return facs_pkg::AUTO_STEP_CYC;
  endfunction

  // Pulse length: register value, never below the minimum
  function automatic logic [23:0] pulse_len(input logic [23:0] v, input logic [23:0] min_v);
    return (v < min_v) ? min_v : v;
  endfunction

  // Array control pins for a sequencer state
  function automatic facs_pkg::facs_ctrl_t ctrl_for(input facs_pkg::facs_seq_t st,
                                                    input facs_pkg::facs_op_t op,
                                                    input logic info, input logic [7:0] a,
                                                    input logic [15:0] d);
    facs_pkg::facs_ctrl_t c;
    logic prog;
    logic mass;
    c = '0;
    prog = (op == facs_pkg::FACS_OP_PROG);
    mass = (op == facs_pkg::FACS_OP_MASS);
    if (st != facs_pkg::FACS_IDLE && st != facs_pkg::FACS_RCV)
    begin
      c.addr = a;
      c.wdata = d;
      c.info_area_select = info;
    end
    case (st)
      facs_pkg::FACS_READ:
      begin
        c.row_select_enable = 1'b1;
        c.column_select_enable = 1'b1;
        c.readout_amp_on = 1'b1;
        c.output_enable = 1'b1;
      end
      facs_pkg::FACS_SETUP, facs_pkg::FACS_PGS, facs_pkg::FACS_PULSE:
      begin
        c.row_select_enable = 1'b1;
        c.write_cycle_strobe = prog;
        c.clear_cycle_strobe = !prog;
        c.whole_block_select = mass;
        c.store_strobe = (st != facs_pkg::FACS_SETUP);
        c.column_select_enable = prog && (st == facs_pkg::FACS_PULSE);
      end
      facs_pkg::FACS_HOLD:
      begin
        c.row_select_enable = 1'b1;
        c.whole_block_select = mass;
        c.store_strobe = 1'b1;
      end
      default:
      begin
        c.store_strobe = 1'b0;
      end
    endcase
    return c;
  endfunction

  // Register read decode: {resp, data}
  function automatic logic [33:0] reg_read(input facs_state_t s, input logic [7:0] a);
    logic [3:0] ti;
    ti = time_index(a);
    case ({a[7:2], 2'b00})
      facs_pkg::REG_CTRL:
        return {facs_pkg::RESP_OKAY, 27'h0, s.cfg_manual, s.cfg_info, s.cfg_op, 1'b0};
      facs_pkg::REG_ADDR:   return {facs_pkg::RESP_OKAY, 24'h0, s.addr};
      facs_pkg::REG_WDATA:  return {facs_pkg::RESP_OKAY, 16'h0, s.wdata};
      facs_pkg::REG_STATUS:
        return {facs_pkg::RESP_OKAY, 27'h0, s.ref_budget, s.ref_reprog, s.ref_busy,
                s.done, s.busy};
      facs_pkg::REG_RDATA:  return {facs_pkg::RESP_OKAY, 16'h0, s.rdata};
      default:
      begin
        if (!ti[3])
        begin
          return {facs_pkg::RESP_OKAY, 8'h0, s.tm[ti[2:0]]};
        end
        return {facs_pkg::RESP_SLVERR, 32'h0};
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset image

  always_comb
  begin
    s_rst = '0;
    s_rst.st = facs_pkg::FACS_IDLE;
    s_rst.cfg_op = facs_pkg::FACS_OP_READ;
    s_rst.act_op = facs_pkg::FACS_OP_READ;
    s_rst.cfg_manual = 1'b1;
    s_rst.tm[facs_pkg::TM_PROG] = 24'(facs_pkg::PROG_CYC);
    s_rst.tm[facs_pkg::TM_ERASE] = ERASE_MIN_CYC;
    s_rst.tm[facs_pkg::TM_MASS] = MASS_MIN_CYC;
    s_rst.tm[facs_pkg::TM_NVS] = 24'(facs_pkg::NVS_CYC);
    s_rst.tm[facs_pkg::TM_NVH] = 24'(facs_pkg::NVH_CYC);
    s_rst.tm[facs_pkg::TM_NVH1] = NVH1_RST_CYC;
    s_rst.tm[facs_pkg::TM_PGS] = 24'(facs_pkg::PGS_CYC);
    s_rst.tm[facs_pkg::TM_RCV] = 24'(facs_pkg::RCV_CYC);
    s_rst.awready = 1'b1;
    s_rst.wready = 1'b1;
    s_rst.arready = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    start = 1'b0;
    clr = 5'h00;
    wv = 32'h0;
    tidx = 3'h0;
    tsel = 4'h8;
    rd = 34'h0;
    widx = {s_q.act_info, s_q.addr};
    ridx = {s_q.act_info, s_q.addr[7:4]};
    plen = pulse_len(s_q.tm[facs_pkg::TM_PROG], 24'(facs_pkg::PROG_CYC));
    hv_sum = 25'(s_q.hv_acc[ridx]) + 25'(plen);

    // Write channel
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_have = 1'b1;
      s_d.wdat = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_d.aw_have && s_d.w_have && !s_d.bvalid)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = facs_pkg::RESP_OKAY;
      case ({s_d.awaddr[7:2], 2'b00})
        facs_pkg::REG_CTRL:
        begin
          wv = merge({27'h0, s_q.cfg_manual, s_q.cfg_info, s_q.cfg_op, 1'b0},
                     s_d.wdat, s_d.wstrb);
          s_d.cfg_op = facs_pkg::facs_op_t'(wv[facs_pkg::CTRL_OP_LSB +: 2]);
          s_d.cfg_info = wv[facs_pkg::CTRL_INFO];
          s_d.cfg_manual = wv[facs_pkg::CTRL_MANUAL];
          start = s_d.wstrb[0] && s_d.wdat[facs_pkg::CTRL_START];
        end
        facs_pkg::REG_ADDR:
        begin
          wv = merge({24'h0, s_q.addr}, s_d.wdat, s_d.wstrb);
          s_d.addr = wv[7:0];
        end
        facs_pkg::REG_WDATA:
        begin
          wv = merge({16'h0, s_q.wdata}, s_d.wdat, s_d.wstrb);
          s_d.wdata = wv[15:0];
        end
        facs_pkg::REG_STATUS:
        begin
          clr = s_d.wstrb[0] ? s_d.wdat[4:0] : 5'h00;
        end
        facs_pkg::REG_RDATA:
        begin
          s_d.bresp = facs_pkg::RESP_OKAY;
        end
        default:
        begin
          tsel = time_index(s_d.awaddr);
          if (!tsel[3])
          begin
            tidx = tsel[2:0];
            wv = merge({8'h0, s_q.tm[tidx]}, s_d.wdat, s_d.wstrb);
            s_d.tm[tidx] = wv[23:0];
          end
          else
          begin
            s_d.bresp = facs_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    s_d.awready = !s_d.aw_have;
    s_d.wready = !s_d.w_have;

    // Read channel
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready)
    begin
      rd = reg_read(s_q, s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp = rd[33:32];
      s_d.rdat = rd[31:0];
    end
    s_d.arready = !s_d.rvalid;

    // Sticky status: clear first so a same-cycle set wins
    s_d.done = s_q.done && !clr[facs_pkg::STAT_DONE];
    s_d.ref_busy = s_q.ref_busy && !clr[facs_pkg::STAT_REF_BUSY];
    s_d.ref_reprog = s_q.ref_reprog && !clr[facs_pkg::STAT_REF_REPROG];
    s_d.ref_budget = s_q.ref_budget && !clr[facs_pkg::STAT_REF_BUDGET];

    // Sequencer
    if (s_q.st != facs_pkg::FACS_IDLE && s_q.cnt != 24'h000000)
    begin
      s_d.cnt = s_q.cnt - 24'h000001;
    end
    case (s_q.st)
      facs_pkg::FACS_IDLE:
      begin
        if (start)
        begin
          s_d.act_op = s_d.cfg_op;
          s_d.act_info = s_d.cfg_info;
          s_d.act_manual = s_d.cfg_manual;
          widx = {s_d.cfg_info, s_d.addr};
          ridx = {s_d.cfg_info, s_d.addr[7:4]};
          hv_sum = 25'(s_q.hv_acc[ridx]) + 25'(plen);
          if (s_d.cfg_op == facs_pkg::FACS_OP_READ)
          begin
            s_d.st = facs_pkg::FACS_READ;
            s_d.cnt = 24'h000001;
          end
          else if (s_d.cfg_op == facs_pkg::FACS_OP_PROG && s_q.prog_map[widx])
          begin
            s_d.ref_reprog = 1'b1;
          end
          else if (s_d.cfg_op == facs_pkg::FACS_OP_PROG && hv_sum > 25'(HV_BUDGET_CYC))
          begin
            s_d.ref_budget = 1'b1;
          end
          else
          begin
            s_d.st = facs_pkg::FACS_SETUP;
            s_d.cnt = step_len(s_d.cfg_manual, s_q.tm[facs_pkg::TM_NVS]) - 24'h000001;
          end
        end
      end
      facs_pkg::FACS_READ:
      begin
        if (s_q.cnt == 24'h000000)
        begin
          s_d.rdata = flash_rdata;
          s_d.done = 1'b1;
          s_d.st = facs_pkg::FACS_IDLE;
        end
      end
      facs_pkg::FACS_SETUP:
      begin
        if (s_q.cnt == 24'h000000)
        begin
          if (s_q.act_op == facs_pkg::FACS_OP_PROG)
          begin
            s_d.st = facs_pkg::FACS_PGS;
            s_d.cnt = step_len(s_q.act_manual, s_q.tm[facs_pkg::TM_PGS]) - 24'h000001;
          end
          else
          begin
            s_d.st = facs_pkg::FACS_PULSE;
            s_d.cnt = (s_q.act_op == facs_pkg::FACS_OP_MASS)
                    ? pulse_len(s_q.tm[facs_pkg::TM_MASS], MASS_MIN_CYC) - 24'h000001
                    : pulse_len(s_q.tm[facs_pkg::TM_ERASE], ERASE_MIN_CYC) - 24'h000001;
          end
        end
      end
      facs_pkg::FACS_PGS:
      begin
        if (s_q.cnt == 24'h000000)
        begin
          s_d.st = facs_pkg::FACS_PULSE;
          s_d.cnt = plen - 24'h000001;
          s_d.hv_acc[ridx] = hv_sum[23:0];
          s_d.prog_map[widx] = 1'b1;
        end
      end
      facs_pkg::FACS_PULSE:
      begin
        if (s_q.cnt == 24'h000000)
        begin
          s_d.st = facs_pkg::FACS_HOLD;
          s_d.cnt = (s_q.act_op == facs_pkg::FACS_OP_MASS)
                  ? step_len(s_q.act_manual, s_q.tm[facs_pkg::TM_NVH1]) - 24'h000001
                  : step_len(s_q.act_manual, s_q.tm[facs_pkg::TM_NVH]) - 24'h000001;
          if (s_q.act_op != facs_pkg::FACS_OP_PROG)
          begin
            for (int r = 0; r < 32; r++)
            begin
              if ((s_q.act_op == facs_pkg::FACS_OP_PAGE && 5'(r) == ridx) ||
                  (s_q.act_op == facs_pkg::FACS_OP_MASS && (s_q.act_info || r < 16)))
              begin
                s_d.hv_acc[r] = 24'h000000;
                s_d.prog_map[r*16 +: 16] = 16'h0000;
              end
            end
          end
        end
      end
      facs_pkg::FACS_HOLD:
      begin
        if (s_q.cnt == 24'h000000)
        begin
          s_d.st = facs_pkg::FACS_RCV;
          s_d.cnt = step_len(s_q.act_manual, s_q.tm[facs_pkg::TM_RCV]) - 24'h000001;
        end
      end
      facs_pkg::FACS_RCV:
      begin
        if (s_q.cnt == 24'h000000)
        begin
          s_d.st = facs_pkg::FACS_IDLE;
          s_d.done = 1'b1;
        end
      end
      default:
      begin
        s_d.st = facs_pkg::FACS_IDLE;
      end
    endcase
    if (start && s_q.st != facs_pkg::FACS_IDLE)
    begin
      s_d.ref_busy = 1'b1;
    end
    s_d.busy = (s_d.st != facs_pkg::FACS_IDLE);
    s_d.ctrl = ctrl_for(s_d.st, s_d.act_op, s_d.act_info, s_d.addr, s_d.wdata);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= s_rst;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdat;
  assign s_axi_rresp = s_q.rresp;
  assign flash_ctrl = s_q.ctrl;
  assign busy = s_q.busy;

endmodule

// ### shared/facs_pkg.sv
// Package: constants and types of the flash array control sequencer
package facs_pkg;

  localparam int CLK_MHZ = 50;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_TIME0  = 8'h14;
  localparam logic [7:0] REG_TIME7  = 8'h30;

  // Timing register indices, one word each from REG_TIME0 upward
  localparam int TM_PROG = 0;
  localparam int TM_ERASE = 1;
  localparam int TM_MASS = 2;
  localparam int TM_NVS = 3;
  localparam int TM_NVH = 4;
  localparam int TM_NVH1 = 5;
  localparam int TM_PGS = 6;
  localparam int TM_RCV = 7;

  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_INFO = 3;
  localparam int CTRL_MANUAL = 4;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_REF_BUSY = 2;
  localparam int STAT_REF_REPROG = 3;
  localparam int STAT_REF_BUDGET = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Times as printed and their cycle counts at CLK_MHZ
  localparam int T_PROG_US = 20;
  localparam int T_ERASE_MS = 20;
  localparam int T_MASS_MS = 100;
  localparam int STORE_SETUP_INTERVAL_US = 5;
  localparam int STORE_HOLD_INTERVAL_US = 5;
  localparam int T_NVH1_US = 100;
  localparam int STORE_TO_WRITE_SETUP_US = 10;
  localparam int T_RCV_US = 1;
  localparam int T_HV_MS = 3;
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int MASS_CYC = T_MASS_MS * 1000 * CLK_MHZ;
  localparam int NVS_CYC = STORE_SETUP_INTERVAL_US * CLK_MHZ;
  localparam int NVH_CYC = STORE_HOLD_INTERVAL_US * CLK_MHZ;
  localparam int NVH1_CYC = T_NVH1_US * CLK_MHZ;
  localparam int PGS_CYC = STORE_TO_WRITE_SETUP_US * CLK_MHZ;
  localparam int RCV_CYC = T_RCV_US * CLK_MHZ;
  localparam int HV_CYC = T_HV_MS * 1000 * CLK_MHZ;
  localparam logic [23:0] AUTO_STEP_CYC = 24'h000001;

  typedef enum logic [1:0] {
    FACS_OP_READ = 2'h0,
    FACS_OP_PROG = 2'h1,
    FACS_OP_PAGE = 2'h2,
    FACS_OP_MASS = 2'h3
  } facs_op_t;

  typedef enum logic [6:0] {
    FACS_IDLE  = 7'h01,
    FACS_READ  = 7'h02,
    FACS_SETUP = 7'h04,
    FACS_PGS   = 7'h08,
    FACS_PULSE = 7'h10,
    FACS_HOLD  = 7'h20,
    FACS_RCV   = 7'h40
  } facs_seq_t;

  // Control port of the flash array
  typedef struct packed {
    logic        row_select_enable;
    logic        column_select_enable;
    logic        readout_amp_on;
    logic        output_enable;
    logic        write_cycle_strobe;
    logic        clear_cycle_strobe;
    logic        whole_block_select;
    logic        store_strobe;
    logic        info_area_select;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } facs_ctrl_t;

endpackage

// ### test/facs_monitor.sv
// Checker of the array control sequence at the top-level ports
module facs_monitor #(
  parameter logic [23:0] ERASE_MIN_CYC = 24'h000014,
  parameter logic [23:0] MASS_MIN_CYC  = 24'h000028
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire facs_pkg::facs_ctrl_t flash_ctrl,
  input wire logic                 busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        rw, cl, am, oe, wr, er, wb, st, pulse;
  logic [23:0] pcnt_q;
  assign rw = flash_ctrl.row_select_enable;
  assign cl = flash_ctrl.column_select_enable;
  assign am = flash_ctrl.readout_amp_on;
  assign oe = flash_ctrl.output_enable;
  assign wr = flash_ctrl.write_cycle_strobe;
  assign er = flash_ctrl.clear_cycle_strobe;
  assign wb = flash_ctrl.whole_block_select;
  assign st = flash_ctrl.store_strobe;
  assign pulse = st && (cl || er);
  // Length of the current high-voltage pulse
  always_ff @(posedge aclk)
    pcnt_q <= (!aresetn || !pulse) ? 24'h000000 : pcnt_q + 24'h000001;
  ////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_prog_end; $fell(pulse) && $past(wr); endsequence
  sequence s_page_end; $fell(pulse) && $past(er && !wb); endsequence
  sequence s_mass_end; $fell(pulse) && $past(wb); endsequence
  property p_standby; !busy && !oe |-> !(rw || cl || am || wr || er || wb || st); endproperty
  a_standby: assert property (p_standby) else $error("array control active while idle");
  property p_read; oe |-> rw && cl && am && !wr && !er && !wb && !st; endproperty
  a_read: assert property (p_read) else $error("read encoding wrong");
  property p_prog; wr |-> rw && !am && !oe && !er && !wb; endproperty
  a_prog: assert property (p_prog) else $error("program encoding wrong");
  property p_erase; er |-> rw && !cl && !am && !oe && !wr; endproperty
  a_erase: assert property (p_erase) else $error("erase encoding wrong");
  property p_whole; wb |-> rw && !cl && (er || st); endproperty
  a_whole: assert property (p_whole) else $error("whole block select misused");
  property p_setup; $rose(st) |-> $past(wr || er); endproperty
  a_setup: assert property (p_setup) else $error("store strobe without setup");
  property p_pgs; $rose(cl) && wr |-> $past(st); endproperty
  a_pgs: assert property (p_pgs) else $error("program pulse before store");
  property p_prog_min; s_prog_end |-> pcnt_q >= 24'h0003e8; endproperty
  a_prog_min: assert property (p_prog_min) else $error("program pulse short");
  property p_page_min; s_page_end |-> pcnt_q >= ERASE_MIN_CYC; endproperty
  a_page_min: assert property (p_page_min) else $error("erase pulse short");
  property p_mass_min; s_mass_end |-> pcnt_q >= MASS_MIN_CYC; endproperty
  a_mass_min: assert property (p_mass_min) else $error("mass erase pulse short");
  property p_hold; $fell(pulse) |-> st; endproperty
  a_hold: assert property (p_hold) else $error("store strobe without hold");
  property p_rcv; $fell(st) |-> busy && !rw; endproperty
  a_rcv: assert property (p_rcv) else $error("no recovery after store");
endmodule

bind facs_top facs_monitor #(.ERASE_MIN_CYC(ERASE_MIN_CYC), .MASS_MIN_CYC(MASS_MIN_CYC)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .flash_ctrl(flash_ctrl), .busy(busy));

// ### test/facs_flash_model.sv
// Behavioural model of the flash array data output
module facs_flash_model (
  input wire logic                 aclk,
  input wire facs_pkg::facs_ctrl_t fc,
  output logic [15:0]              flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] junk_q = 16'h0000;
  always @(posedge aclk) junk_q <= junk_q + 16'h1357;
  // Data only with output enable, rows, columns and sense amp on; else a floating bus
  assign flash_rdata = (fc.output_enable && fc.row_select_enable && fc.column_select_enable
    && fc.readout_amp_on) ? 16'ha500 ^ {7'h00, fc.info_area_select, fc.addr} : junk_q;
endmodule

// ### test/testbench.sv
// Self-checking bench of the flash array control sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } facs_row_t;
  localparam facs_row_t ROWS[18] = '{
    '{1'h0, 8'h00, 32'h0, 32'h10, 2'h0}, '{1'h0, 8'h0c, 32'h0, 32'h0, 2'h0},
    '{1'h0, 8'h14, 32'h0, 32'h3e8, 2'h0}, '{1'h0, 8'h20, 32'h0, 32'hfa, 2'h0},
    '{1'h0, 8'h24, 32'h0, 32'hfa, 2'h0}, '{1'h0, 8'h28, 32'h0, 32'h8, 2'h0},
    '{1'h0, 8'h2c, 32'h0, 32'h1f4, 2'h0}, '{1'h0, 8'h30, 32'h0, 32'h32, 2'h0},
    '{1'h0, 8'h40, 32'h0, 32'h0, 2'h2}, '{1'h1, 8'h20, 32'hff000003, 32'h3, 2'h0},
    '{1'h1, 8'h24, 32'h3, 32'h3, 2'h0}, '{1'h1, 8'h28, 32'h5, 32'h5, 2'h0},
    '{1'h1, 8'h2c, 32'h4, 32'h4, 2'h0}, '{1'h1, 8'h30, 32'h2, 32'h2, 2'h0},
    '{1'h1, 8'h18, 32'h1, 32'h1, 2'h0}, '{1'h1, 8'h1c, 32'h1, 32'h1, 2'h0},
    '{1'h1, 8'h10, 32'hffff, 32'h0, 2'h0}, '{1'h1, 8'h44, 32'h1, 32'h0, 2'h2}};
  logic                 aclk = 1'h0;
  logic                 aresetn = 1'h0;
  logic [7:0]           awaddr = 8'h00;
  logic [7:0]           araddr = 8'h00;
  logic [31:0]          wdata = 32'h0;
  logic                 awvalid = 1'h0;
  logic                 wvalid = 1'h0;
  logic                 arvalid = 1'h0;
  logic                 bready = 1'h0;
  logic                 rready = 1'h0;
  logic                 awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]           bresp, rresp, r;
  logic [31:0]          rdata, v;
  logic [15:0]          frd, pd;
  logic [7:0]           pa;
  facs_pkg::facs_ctrl_t fc;
  int                   cnt[7];
  int                   k;
  int                   mismatches = 0;
  int                   cmp_count = 0;
  always #10 aclk = ~aclk;
  facs_top #(.ERASE_MIN_CYC(24'h000014), .MASS_MIN_CYC(24'h000028),
    .NVH1_RST_CYC(24'h000008), .HV_BUDGET_CYC(24'h0009c4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_ctrl(fc), .flash_rdata(frd), .busy(busy));
  facs_flash_model u_flash (.aclk(aclk), .fc(fc), .flash_rdata(frd));
  ////////////////////////////////////////
  function automatic int cls(input facs_pkg::facs_ctrl_t c, input logic b);
    if (c.output_enable) return 5;
    if (c.store_strobe && (c.column_select_enable || c.clear_cycle_strobe)) return 2;
    if (c.store_strobe) return c.write_cycle_strobe ? 1 : 3;
    if (c.write_cycle_strobe || c.clear_cycle_strobe) return 0;
    return b ? 4 : 6;
  endfunction
  // Cycles spent in each phase: setup, store setup, pulse, hold, recovery, read
  always @(posedge aclk)
  begin
    k = cls(fc, busy);
    cnt[k] <= cnt[k] + 1;
    if (k == 2)
    begin
      pa <= fc.addr;
      pd <= fc.wdata;
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stall();
    mismatches++;
    $display("[FAIL] handshake expected answer seen none");
    complete_run();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (i == 50) stall();
    bready <= 1'h0;
    r = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (i == 50) stall();
    rready <= 1'h0;
    v = rdata;
    r = rresp;
  endtask
  task automatic op(input logic [31:0] c, input logic [7:0] a, input int e[6],
                    input logic [31:0] s, input bit twice);
    int i;
    axw(facs_pkg::REG_STATUS, 32'h1e);
    axw(facs_pkg::REG_ADDR, {24'h0, a});
    axw(facs_pkg::REG_WDATA, 32'hbeef);
    cnt <= '{default: 0};
    axw(facs_pkg::REG_CTRL, c);
    if (twice) axw(facs_pkg::REG_CTRL, c);
    for (i = 0; i < 2000 && busy; i++) @(posedge aclk);
    if (i == 2000) stall();
    axr(facs_pkg::REG_STATUS);
    for (i = 0; i < 6; i++) chk("phase cycles", 32'(cnt[i]), 32'(e[i]));
    chk("status", v, s);
    if (e[2] > 0 && c[2:1] == 2'h1) chk("pulse word", {pa, pd}, {a, 16'hbeef});
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (ROWS[n])
    begin
      if (ROWS[n].wr)
      begin
        axw(ROWS[n].a, ROWS[n].d);
        chk("write response", 32'(r), 32'(ROWS[n].r));
      end
      axr(ROWS[n].a);
      chk("register word", v, ROWS[n].e);
      chk("read response", 32'(r), 32'(ROWS[n].r));
    end
    op(32'h19, 8'h23, '{0, 0, 0, 0, 0, 2}, 32'h2, 1'b0);
    axr(facs_pkg::REG_RDATA);
    chk("info block word", v, 32'ha423);
    op(32'h11, 8'h23, '{0, 0, 0, 0, 0, 2}, 32'h2, 1'b0);
    axr(facs_pkg::REG_RDATA);
    chk("main block word", v, 32'ha523);
    op(32'h13, 8'h23, '{3, 4, 1000, 3, 2, 0}, 32'h2, 1'b0);
    op(32'h13, 8'h23, '{0, 0, 0, 0, 0, 0}, 32'h8, 1'b0);
    op(32'h03, 8'h24, '{1, 1, 1000, 1, 1, 0}, 32'h2, 1'b0);
    op(32'h13, 8'h25, '{0, 0, 0, 0, 0, 0}, 32'h10, 1'b0);
    op(32'h15, 8'h20, '{3, 0, 20, 3, 2, 0}, 32'h2, 1'b0);
    op(32'h13, 8'h23, '{3, 4, 1000, 3, 2, 0}, 32'h2, 1'b0);
    op(32'h1f, 8'h00, '{3, 0, 40, 5, 2, 0}, 32'h2, 1'b0);
    op(32'h13, 8'h30, '{3, 4, 1000, 3, 2, 0}, 32'h6, 1'b1);
    axw(facs_pkg::REG_ADDR, 32'h31);
    axw(facs_pkg::REG_CTRL, 32'h13);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("control after reset", 32'(fc == '0), 32'h1);
    chk("busy after reset", 32'(busy), 32'h0);
    complete_run();
  end
endmodule
